/* src/dpot_map.svh */
// Constant map of the two-wire potentiometer slave: codes, fields, timing.
`ifndef DPOT_MAP_SVH
`define DPOT_MAP_SVH

// ==========================================================================
// Command byte fields and instruction codes
`define DPOT_INS_MSB 7
`define DPOT_INS_LSB 4
`define DPOT_SEL_MSB 3
`define DPOT_SEL_LSB 2
`define DPOT_INS_RD_WCR 4'h9
`define DPOT_INS_WR_WCR 4'hA
`define DPOT_INS_RD_DR 4'hB
`define DPOT_INS_WR_DR 4'hC
`define DPOT_INS_XFR_DW 4'hD
`define DPOT_INS_XFR_WD 4'hE
`define DPOT_INS_INCDEC 4'h2

// ==========================================================================
// Slave address fields and reset values
`define DPOT_TYPE_MSB 7
`define DPOT_TYPE_LSB 4
`define DPOT_DEV_MSB 3
`define DPOT_WIPER_RST 6'h00
`define DPOT_WIPER_MAX 6'h3F

// ==========================================================================
// Timing
`define DPOT_CLK_MHZ 200
`define DPOT_NV_TYP_US 5000
`define DPOT_NV_MAX_US 10000

`endif

/* src/dpot_pkg.sv */
// Types shared by the potentiometer slave and its queue.
package dpot_pkg;

    typedef enum logic [2:0] {
        OP_WR_WCR,
        OP_WR_DR,
        OP_XFR_DW,
        OP_XFR_WD,
        OP_INC,
        OP_DEC
    } dpot_op_t;

    typedef struct packed {
        dpot_op_t op;
        logic [1:0] sel;
        logic [5:0] data;
    } dpot_item_t;

endpackage : dpot_pkg

/* src/dpot_fifo.sv */
// Small synchronous queue with valid and ready on both sides.
`timescale 1ns/1ps
module dpot_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_reg != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_reg[rd_reg];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : dpot_fifo

/* src/dpot_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module dpot_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Asynchronous pins in, synchronised levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    // Pins idle high on the bus, so reset to ones avoids a false start.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= '1;
            o_sync <= '1;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end

endmodule : dpot_sync

/* src/dpot_slave.sv */
// Two-wire slave, command queue, stored settings and wiper tap decoder.
//
// How it works
// - Low three device-address bits come from the strap inputs.
// - Address is acknowledged only when all four device bits match.
// - Data changes only with clock low; high-clock changes mark start/stop.
// - Start is data falling with clock high; nothing happens before it.
// - Transmitter releases data after eight bits; receiver acks ninth.
// - Acknowledge after address, after command, after a data byte.
// - Master makes the clock; this slave never drives it.
// - Data pin is open drain: pull low or release.
// - Write-protect low blocks every stored-setting write.
// - Six-bit wiper decodes to exactly one of sixty-four taps.
// - Wiper takes direct writes or copies from four stored settings.
// - Stop after a stored-setting write starts the timed write cycle.
// - During the write cycle the own address is not acknowledged.
// - Command: instruction in top nibble, register select next, low zero.
// - A stored-setting operation finishes within the maximum time.
`timescale 1ns/1ps
`include "dpot_map.svh"
module dpot_slave #(
    parameter logic [3:0] TYPE_ID = 4'h6, // Arbitrary value.
    parameter logic ADDR_BIT3 = 1'b0,
    parameter logic [5:0] DR_RST = `DPOT_WIPER_RST,
    parameter int NV_CYCLES = `DPOT_NV_TYP_US * `DPOT_CLK_MHZ,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Two-wire bus pins
    input wire logic i_scl,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Straps and protection
    input wire logic [2:0] i_addr_strap_inputs,
    input wire logic i_wp_n,
    // Potentiometer side
    output logic [63:0] o_tap_sel,
    output logic [5:0] o_wiper_position,
    output logic o_nv_busy
);
    localparam int NV_MAX = `DPOT_NV_MAX_US * `DPOT_CLK_MHZ;
    localparam int CW = $clog2(NV_CYCLES + 1);
    localparam int IW = $bits(dpot_pkg::dpot_item_t);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_RX,
        ST_TX,
        ST_INCDEC,
        ST_DONE
    } dpot_state_t;

    // ======================================================================
    // Pin synchronisation and bus events
    logic [5:0] pins;
    logic scl;
    logic sda;
    logic wp_n;
    logic [2:0] strap;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;

    dpot_sync #(
        .WIDTH(6)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_async({i_scl, i_sda_i, i_wp_n, i_addr_strap_inputs}),
        .o_sync(pins)
    );

    assign scl = pins[5];
    assign sda = pins[4];
    assign wp_n = pins[3];
    assign strap = pins[2:0];

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl;
            sda_prev_reg <= sda;
        end
    end

    // Data moving while the clock stays high is a start or a stop.
    assign start_ev = scl && scl_prev_reg && sda_prev_reg && !sda;
    assign stop_ev = scl && scl_prev_reg && !sda_prev_reg && sda;
    assign scl_rise = scl && !scl_prev_reg;
    assign scl_fall = !scl && scl_prev_reg;

    // ======================================================================
    // Serial engine
    dpot_state_t state_reg;
    dpot_state_t after_reg;
    logic [3:0] cnt_reg;
    logic [6:0] sh_reg;
    logic [7:0] tx_reg;
    logic [7:0] cmd_reg;
    logic ack_reg;
    logic nv_seen_reg;
    logic [7:0] rx_byte;
    logic [3:0] dev_addr;
    logic [5:0] dr_reg [4];
    logic [5:0] wiper_reg;
    logic nv_busy_reg;
    logic push;
    logic in_ready;
    dpot_pkg::dpot_item_t item;

    assign rx_byte = {sh_reg, sda};
    assign dev_addr = {ADDR_BIT3, strap};

    // Bytes queue at the clock rise, steps at its fall, so a stop is no step.
    always_comb begin
        push = 1'b0;
        item.op = dpot_pkg::OP_WR_WCR;
        item.sel = cmd_reg[`DPOT_SEL_MSB:`DPOT_SEL_LSB];
        item.data = rx_byte[5:0];
        if ((scl_rise || scl_fall) && !start_ev && !stop_ev) begin
            if (scl && state_reg == ST_RX && cnt_reg == 4'h7) begin
                push = 1'b1;
                item.op = (cmd_reg[7:4] == `DPOT_INS_WR_DR) ?
                          dpot_pkg::OP_WR_DR : dpot_pkg::OP_WR_WCR;
            end else if (scl && state_reg == ST_CMD && cnt_reg == 4'h7) begin
                item.sel = rx_byte[`DPOT_SEL_MSB:`DPOT_SEL_LSB];
                if (rx_byte[7:4] == `DPOT_INS_XFR_DW) begin
                    push = (rx_byte[1:0] == 2'h0);
                    item.op = dpot_pkg::OP_XFR_DW;
                end else if (rx_byte[7:4] == `DPOT_INS_XFR_WD) begin
                    push = (rx_byte[1:0] == 2'h0);
                    item.op = dpot_pkg::OP_XFR_WD;
                end
            end else if (!scl && state_reg == ST_INCDEC) begin
                push = 1'b1;
                item.op = sda_prev_reg ? dpot_pkg::OP_INC : dpot_pkg::OP_DEC;
            end
        end
    end

    // Bit counting, byte decisions and the acknowledge slot.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            after_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 7'h00;
            cmd_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else if (start_ev) begin
            state_reg <= ST_ADDR;
            cnt_reg <= 4'h0;
            ack_reg <= 1'b0;
        end else if (stop_ev) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            ack_reg <= 1'b0;
        end else if (state_reg == ST_IDLE || state_reg == ST_INCDEC) begin
            cnt_reg <= 4'h0;
        end else if (scl_rise) begin
            cnt_reg <= (cnt_reg == 4'h8) ? 4'h9 : cnt_reg + 4'h1;
            sh_reg <= rx_byte[6:0];
            if (cnt_reg == 4'h7) begin
                ack_reg <= 1'b0;
                after_reg <= ST_DONE;
                unique case (state_reg)
                    ST_ADDR: begin
                        if (rx_byte[7:4] == TYPE_ID && rx_byte[3:0] == dev_addr
                            && !nv_busy_reg) begin
                            ack_reg <= 1'b1;
                            after_reg <= ST_CMD;
                        end else begin
                            after_reg <= ST_IDLE;
                        end
                    end
                    ST_CMD: begin
                        cmd_reg <= rx_byte;
                        ack_reg <= (rx_byte[1:0] == 2'h0) && (!push || in_ready);
                        unique case (rx_byte[7:4])
                            `DPOT_INS_RD_WCR, `DPOT_INS_RD_DR: after_reg <= ST_TX;
                            `DPOT_INS_WR_WCR, `DPOT_INS_WR_DR: after_reg <= ST_RX;
                            `DPOT_INS_INCDEC: after_reg <= ST_INCDEC;
                            `DPOT_INS_XFR_DW, `DPOT_INS_XFR_WD: after_reg <= ST_DONE;
                            default: ack_reg <= 1'b0;
                        endcase
                    end
                    ST_RX: ack_reg <= in_ready;
                    default: ack_reg <= 1'b0;
                endcase
            end
        end else if (scl_fall && cnt_reg == 4'h9) begin
            cnt_reg <= 4'h0;
            state_reg <= ack_reg ? after_reg : ST_IDLE;
        end
    end

    // Read data is captured as the command byte completes.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_reg <= 8'h00;
        end else if (scl_rise && state_reg == ST_CMD && cnt_reg == 4'h7) begin
            tx_reg <= {2'h0, (rx_byte[7:4] == `DPOT_INS_RD_WCR) ? wiper_reg :
                       dr_reg[rx_byte[`DPOT_SEL_MSB:`DPOT_SEL_LSB]]};
        end
    end

    // Open-drain drive, changed on falling clock edges and released at a start or a stop.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sda_oe <= 1'b0;
        end else if (start_ev || stop_ev) begin
            o_sda_oe <= 1'b0;
        end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
                o_sda_oe <= ack_reg && state_reg != ST_TX;
            end else if (cnt_reg == 4'h9) begin
                o_sda_oe <= ack_reg && after_reg == ST_TX && !tx_reg[7];
            end else if (state_reg == ST_TX && cnt_reg < 4'h8) begin
                o_sda_oe <= !tx_reg[3'h7 - cnt_reg[2:0]];
            end else begin
                o_sda_oe <= 1'b0;
            end
        end
    end

    assign o_sda_o = 1'b0;

    // A stored-setting command in this transfer arms the write cycle.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            nv_seen_reg <= 1'b0;
        end else if (start_ev || stop_ev) begin
            nv_seen_reg <= 1'b0;
        end else if (push && in_ready && (item.op == dpot_pkg::OP_WR_DR
                     || item.op == dpot_pkg::OP_XFR_WD)) begin
            nv_seen_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Command queue and register executor
    dpot_pkg::dpot_item_t q_item;
    logic q_valid;
    logic q_ready;
    logic pend_reg;
    logic [1:0] pend_sel_reg;
    logic [5:0] pend_val_reg;
    logic [CW-1:0] nv_cnt_reg;

    dpot_fifo #(
        .WIDTH(IW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_in_valid(push),
        .i_in_data(item),
        .o_in_ready(in_ready),
        .o_out_valid(q_valid),
        .o_out_data(q_item),
        .i_out_ready(q_ready)
    );

    // The queue stalls while the stored settings are being written.
    assign q_ready = !nv_busy_reg;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wiper_reg <= DR_RST;
        end else if (q_valid && q_ready) begin
            unique case (q_item.op)
                dpot_pkg::OP_WR_WCR: wiper_reg <= q_item.data;
                dpot_pkg::OP_XFR_DW: wiper_reg <= dr_reg[q_item.sel];
                dpot_pkg::OP_INC: if (wiper_reg != `DPOT_WIPER_MAX) begin
                    wiper_reg <= wiper_reg + 6'h01;
                end
                dpot_pkg::OP_DEC: if (wiper_reg != 6'h00) begin
                    wiper_reg <= wiper_reg - 6'h01;
                end
                default: wiper_reg <= wiper_reg;
            endcase
        end
    end

    // Pending stored-setting value, committed when the timed cycle ends.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_reg <= 1'b0;
            pend_sel_reg <= 2'h0;
            pend_val_reg <= 6'h00;
        end else if (q_valid && q_ready && (q_item.op == dpot_pkg::OP_WR_DR
                     || q_item.op == dpot_pkg::OP_XFR_WD)) begin
            pend_reg <= 1'b1;
            pend_sel_reg <= q_item.sel;
            pend_val_reg <= (q_item.op == dpot_pkg::OP_WR_DR) ?
                            q_item.data : wiper_reg;
        end else if (stop_ev && !nv_busy_reg && !wp_n) begin
            pend_reg <= 1'b0;
        end else if (nv_busy_reg && nv_cnt_reg == CW'(1)) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            nv_busy_reg <= 1'b0;
            nv_cnt_reg <= '0;
        end else if (!nv_busy_reg) begin
            if (stop_ev && nv_seen_reg && pend_reg && wp_n) begin
                nv_busy_reg <= 1'b1;
                nv_cnt_reg <= CW'(NV_CYCLES);
            end
        end else if (nv_cnt_reg == CW'(1)) begin
            nv_busy_reg <= 1'b0;
            nv_cnt_reg <= '0;
        end else begin
            nv_cnt_reg <= nv_cnt_reg - CW'(1);
        end
    end

    // Stored settings survive reset only as their reset values here.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dr_reg <= '{DR_RST, DR_RST, DR_RST, DR_RST};
        end else if (nv_busy_reg && nv_cnt_reg == CW'(1) && pend_reg) begin
            dr_reg[pend_sel_reg] <= pend_val_reg;
        end
    end

    // ======================================================================
    // Tap decoder and outputs
    genvar gi;
    generate
        for (gi = 0; gi < 64; gi++) begin : g_tap
            always_ff @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    o_tap_sel[gi] <= (DR_RST == 6'(gi));
                end else begin
                    o_tap_sel[gi] <= (wiper_reg == 6'(gi));
                end
            end
        end
    endgenerate

    assign o_wiper_position = wiper_reg;
    assign o_nv_busy = nv_busy_reg;

    initial begin
        if (NV_CYCLES > NV_MAX) begin
            $error("Write cycle longer than the allowed maximum.");
        end
    end

endmodule : dpot_slave

/* verif/ptwsi_sva.sv */
// Concurrent checks on the pins of the potentiometer slave.
`timescale 1ns/1ps
module ptwsi_sva #(
    parameter int NV_CYCLES = 200
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Bus pins
    input wire logic i_scl,
    input wire logic i_sda_i,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    // Straps and protection
    input wire logic [2:0] i_addr_strap_inputs,
    input wire logic i_wp_n,
    // Potentiometer side
    input wire logic [63:0] o_tap_sel,
    input wire logic [5:0] o_wiper_position,
    input wire logic o_nv_busy
);
    // ======================================================================
    // Write cycle length
    int busy_cnt_reg;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_cnt_reg <= 0;
        end else begin
            busy_cnt_reg <= o_nv_busy ? busy_cnt_reg + 1 : 0;
        end
    end

    // ======================================================================
    // Properties
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    AST_SDA_LOW_ONLY:
    assert property (o_sda_o == 1'h0) else $error("data pin driven high");
    AST_TAP_ONE_HOT:
    assert property ($onehot(o_tap_sel)) else $error("tap select not one-hot");
    AST_TAP_FOLLOWS:
    assert property (o_tap_sel == (64'h1 << $past(o_wiper_position)))
        else $error("tap select does not follow wiper");
    AST_OE_CLK_LOW:
    assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data pull changed with clock high");
    AST_ACK_HOLD:
    assert property ($rose(o_sda_oe) |=> o_sda_oe [*8])
        else $error("data pull released too early");
    AST_BUSY_LEN:
    assert property ($fell(o_nv_busy) |->
        busy_cnt_reg inside {[NV_CYCLES:NV_CYCLES + 1]})
        else $error("write cycle length wrong");
    AST_BUSY_NO_ACK:
    assert property (o_nv_busy |-> !o_sda_oe)
        else $error("acknowledge during write cycle");
    AST_BUSY_WP:
    assert property ($rose(o_nv_busy) |-> i_wp_n && $past(i_wp_n, 4))
        else $error("write cycle with protection on");
    AST_BUSY_AT_STOP:
    assert property ($rose(o_nv_busy) |-> i_scl && i_sda_i)
        else $error("write cycle not started by a stop");
endmodule : ptwsi_sva

bind dpot_slave ptwsi_sva #(.NV_CYCLES(NV_CYCLES)) u_ptwsi_sva (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_scl(i_scl),
    .i_sda_i(i_sda_i),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .i_addr_strap_inputs(i_addr_strap_inputs),
    .i_wp_n(i_wp_n),
    .o_tap_sel(o_tap_sel),
    .o_wiper_position(o_wiper_position),
    .o_nv_busy(o_nv_busy)
);

/* verif/ptwsi_master.sv */
// Behavioural two-wire bus master driving the clock and data pins.
`timescale 1ns/1ps
module ptwsi_master (
    // Bus pins
    output logic o_scl,
    output logic o_sda_pull,
    input wire logic i_sda
);
    // ======================================================================
    // Bus phases
    // The clock stands high between frames; only frames toggle it.
    initial begin
        o_scl = 1'h1;
        o_sda_pull = 1'h0;
    end

    // Data moves 8 ns into the low phase, never while the clock is high.
    task automatic bit_io(input logic b, output logic got);
        #8 o_sda_pull = ~b;
        #24 o_scl = 1'h1;
        #16 got = i_sda;
        #16 o_scl = 1'h0;
    endtask : bit_io

    task automatic bus_start();
        #8 o_sda_pull = 1'h0;
        #24 o_scl = 1'h1;
        #32 o_sda_pull = 1'h1;
        #32 o_scl = 1'h0;
    endtask : bus_start

    task automatic bus_stop();
        #8 o_sda_pull = 1'h1;
        #24 o_scl = 1'h1;
        #32 o_sda_pull = 1'h0;
        #32;
    endtask : bus_stop

    // Sends the top n bits; only a whole byte gets the ninth clock.
    task automatic put_byte(input logic [7:0] b, input int n,
                            output logic ack);
        logic g;
        ack = 1'h0;
        for (int i = 0; i < n; i++) begin
            bit_io(b[7 - i], g);
        end
        if (n == 8) begin
            bit_io(1'h1, g);
            ack = ~g;
        end
    endtask : put_byte

    task automatic get_byte(output logic [7:0] b);
        logic g;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'h1, b[7 - i]);
        end
        bit_io(1'h1, g);
    endtask : get_byte
endmodule : ptwsi_master

/* verif/test_pot_two_wire_slave_interface.sv */
// Self-checking bench for the two-wire potentiometer slave.
`timescale 1ns/1ps
`define CHK(act, exp) begin \
    samples_checked++; \
    if ((act) !== (exp)) begin \
        err_total++; \
        $display("unexpected at %0t: got %0h want %0h", $time, act, exp); \
    end \
end
module test_pot_two_wire_slave_interface;
    localparam int NV = 200;
    localparam logic [3:0] TYPE = 4'h6; // Arbitrary value.
    logic i_ref_clk;
    logic i_rstn;
    logic [2:0] strap;
    logic wp_n;
    logic scl;
    logic pull;
    logic sda_o;
    logic sda_oe;
    logic [63:0] tap;
    logic [5:0] wiper;
    logic busy;
    logic sda;
    logic [2:0] a;
    logic [7:0] rd;
    logic ok;
    int polls;
    int err_total;
    int samples_checked;
    int cycles;

    // ======================================================================
    // Clock, wire and instances
    initial begin
        i_ref_clk = 1'h0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    assign sda = ~(pull | sda_oe);

    dpot_slave #(.TYPE_ID(TYPE), .NV_CYCLES(NV)) DUT (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_scl(scl),
        .i_sda_i(sda),
        .o_sda_o(sda_o),
        .o_sda_oe(sda_oe),
        .i_addr_strap_inputs(strap),
        .i_wp_n(wp_n),
        .o_tap_sel(tap),
        .o_wiper_position(wiper),
        .o_nv_busy(busy)
    );
    ptwsi_master u_mst (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));

    // ======================================================================
    // Helpers
    function automatic logic [7:0] adr(input logic [2:0] s);
        return {TYPE, 1'h0, s};
    endfunction : adr

    task automatic frame(input logic [7:0] ad, input logic [7:0] cmd,
                         input logic [7:0] dat, input int nb);
        a = 3'h0;
        u_mst.bus_start();
        u_mst.put_byte(ad, 8, a[0]);
        if (nb > 1) u_mst.put_byte(cmd, 8, a[1]);
        if (nb > 2) u_mst.put_byte(dat, 8, a[2]);
        u_mst.bus_stop();
        repeat (8) @(posedge i_ref_clk);
    endtask : frame

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            $display("unexpected at %0t: run too long", $time);
            results();
        end
    end

    // ======================================================================
    // Scenarios
    task automatic t_addr_sweep();
        for (int s = 0; s < 8; s++) begin
            strap <= s[2:0];
            repeat (6) @(posedge i_ref_clk);
            frame(adr(s[2:0]), 8'hA0, {2'h0, 6'(s * 9)}, 3);
            `CHK(a, 3'h7)
            `CHK(wiper, 6'(s * 9))
            `CHK(tap, 64'h1 << (s * 9))
        end
    endtask : t_addr_sweep

    task automatic t_refuse();
        frame(adr(3'h5), 8'hA0, 8'h01, 3);
        `CHK(a, 3'h0)
        frame({4'h3, 1'h0, 3'h7}, 8'hA0, 8'h01, 3);
        `CHK(a, 3'h0)
        frame(adr(3'h7), 8'hA1, 8'h01, 3);
        `CHK(a, 3'h1)
        `CHK(wiper, 6'h3F)
        u_mst.bus_start();
        u_mst.put_byte(adr(3'h7), 8, ok);
        u_mst.put_byte(8'hA0, 4, ok);
        frame(adr(3'h7), 8'hA0, 8'h05, 3);
        `CHK(a, 3'h7)
        `CHK(wiper, 6'h05)
    endtask : t_refuse

    task automatic t_stored();
        frame(adr(3'h7), 8'hC8, 8'h15, 3);
        `CHK(a, 3'h7)
        `CHK(busy, 1'h1)
        polls = 0;
        ok = 1'h0;
        while (!ok && polls < 40) begin
            u_mst.bus_start();
            u_mst.put_byte(adr(3'h7), 8, ok);
            u_mst.bus_stop();
            if (!ok) polls++;
        end
        `CHK(ok, 1'h1)
        `CHK(polls > 0, 1'h1)
        `CHK(busy, 1'h0)
        frame(adr(3'h7), 8'hD8, 8'h00, 2);
        `CHK(a, 3'h3)
        `CHK(wiper, 6'h15)
    endtask : t_stored

    task automatic t_protect();
        wp_n <= 1'h0;
        frame(adr(3'h7), 8'hE4, 8'h00, 2);
        `CHK(busy, 1'h0)
        frame(adr(3'h7), 8'hC4, 8'h3F, 3);
        `CHK(busy, 1'h0)
        frame(adr(3'h7), 8'hD4, 8'h00, 2);
        `CHK(wiper, 6'h00)
        wp_n <= 1'h1;
    endtask : t_protect

    task automatic t_read();
        frame(adr(3'h7), 8'hA0, 8'h2A, 3);
        for (int k = 0; k < 2; k++) begin
            u_mst.bus_start();
            u_mst.put_byte(adr(3'h7), 8, ok);
            u_mst.put_byte(k == 0 ? 8'h90 : 8'hB8, 8, ok);
            u_mst.get_byte(rd);
            u_mst.bus_stop();
            `CHK(rd, k == 0 ? 8'h2A : 8'h15)
        end
    endtask : t_read

    // Three up steps and one down step; the closing stop must add none.
    task automatic t_incdec();
        logic g;
        a = 3'h0;
        u_mst.bus_start();
        u_mst.put_byte(adr(3'h7), 8, a[0]);
        u_mst.put_byte(8'h20, 8, a[1]);
        for (int k = 0; k < 4; k++) begin
            u_mst.bit_io(k != 3, g);
        end
        u_mst.bus_stop();
        repeat (8) @(posedge i_ref_clk);
        `CHK(a, 3'h3)
        `CHK(wiper, 6'h2C)
        `CHK(tap, 64'h1 << 44)
    endtask : t_incdec

    initial begin
        i_rstn = 1'h0;
        strap = 3'h0;
        wp_n = 1'h1;
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (16) @(posedge i_ref_clk);
        i_rstn <= 1'h1;
        repeat (6) @(posedge i_ref_clk);
        `CHK(tap, 64'h1)
        `CHK(sda_oe, 1'h0)
        t_addr_sweep();
        t_refuse();
        t_stored();
        t_protect();
        t_read();
        t_incdec();
        results();
    end
endmodule : test_pot_two_wire_slave_interface
